//--- lcc_pkg.sv
// constants, field layouts and types for the lane conditioning control bank
package lcc_pkg;

  // ------------------------------------------------------------------
  // management bus
  // ------------------------------------------------------------------
  // device address on the management bus; value is arbitrary
  localparam logic [6:0] LCC_SLAVE_ADDR      = 7'h5a;
  localparam logic [3:0] LCC_BITS_PER_BYTE   = 4'h8;

  // ------------------------------------------------------------------
  // register offsets and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] LCC_OFS_L1_BOOST    = 8'h16;
  localparam logic [7:0] LCC_OFS_L1_SWING    = 8'h17;
  localparam logic [7:0] LCC_OFS_L1_EMPH     = 8'h18;
  localparam logic [7:0] LCC_OFS_L1_IDLE_THR = 8'h19;
  localparam logic [7:0] LCC_OFS_L2_MUTE_RATE = 8'h1c;

  localparam logic [7:0] LCC_RST_L1_BOOST    = 8'h20;
  localparam logic [7:0] LCC_RST_L1_SWING    = 8'h03;
  localparam logic [7:0] LCC_RST_L1_EMPH     = 8'h03;
  localparam logic [7:0] LCC_RST_L1_IDLE_THR = 8'h00;
  localparam logic [7:0] LCC_RST_L2_MUTE_RATE = 8'h00;
  localparam logic [7:0] LCC_UNMAPPED_READ   = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int LCC_BOOST_EN_BIT     = 5;
  localparam int LCC_BOOST_GAIN_MSB   = 4;
  localparam int LCC_BOOST_GAIN_LSB   = 3;
  localparam int LCC_BOOST_LVL_MSB    = 2;
  localparam int LCC_BOOST_LVL_LSB    = 0;
  localparam int LCC_SWING_MSB        = 6;
  localparam int LCC_EMPH_PROFILE_BIT = 7;
  localparam int LCC_EMPH_LVL_MSB     = 6;
  localparam int LCC_THR_DEASSERT_MSB = 3;
  localparam int LCC_THR_DEASSERT_LSB = 2;
  localparam int LCC_THR_ASSERT_MSB   = 1;
  localparam int LCC_THR_ASSERT_LSB   = 0;
  localparam int LCC_MUTE_AUTO_BIT    = 5;
  localparam int LCC_MUTE_SEL_BIT     = 4;
  localparam int LCC_RATE_AUTO_BIT    = 1;
  localparam int LCC_RATE_SEL_BIT     = 0;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  localparam int         LCC_NUM_STRAP       = 8;
  localparam logic [5:0] LCC_BOOST_STRAP_VALS [LCC_NUM_STRAP] =
    '{6'h2a, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, 6'h3b, 6'h3d};
  localparam logic [6:0] LCC_SWING_600MV     = 7'h03;
  localparam logic [6:0] LCC_SWING_800MV     = 7'h07;
  localparam logic [6:0] LCC_SWING_1000MV    = 7'h0f;
  localparam logic [6:0] LCC_SWING_1200MV    = 7'h1f;
  localparam logic [6:0] LCC_SWING_1400MV    = 7'h3f;
  localparam logic [7:0] LCC_EMPH_0DB        = 8'h01;
  localparam logic [7:0] LCC_EMPH_M6DB       = 8'h88;
  localparam logic [7:0] LCC_EMPH_M12DB      = 8'ha0;
  localparam logic [7:0] LCC_EMPH_RESERVED   = 8'hc0;
  // idle thresholds in mV per 2-bit code, index = code
  localparam int LCC_THR_DEASSERT_MV [4] = '{110, 150, 170, 190};
  localparam int LCC_THR_ASSERT_MV   [4] = '{70, 110, 130, 150};
  localparam logic       LCC_RATE_2G5        = 1'b0;
  localparam logic       LCC_RATE_5G0        = 1'b1;

  typedef enum logic [3:0] {
    LCC_IDLE, LCC_ADDR, LCC_ADDR_ACK, LCC_REG, LCC_REG_ACK,
    LCC_WDATA, LCC_WDATA_ACK, LCC_RDATA, LCC_RDATA_ACK
  } lcc_state_t;

endpackage : lcc_pkg

//--- lcc_bus_if.sv
// register access carrier between the bus slave and the register bank
`timescale 1ns/10ps
interface lcc_bus_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave (output wr_en, output addr, output wdata, input rdata);
  modport bank  (input wr_en, input addr, input wdata, output rdata);
endinterface : lcc_bus_if

//--- lcc_reg_bank.sv
// lane control register storage and read-back selection
`timescale 1ns/10ps
module lcc_reg_bank (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  lcc_bus_if.bank         bus,
  output logic [7:0]      boost_q,
  output logic [7:0]      swing_q,
  output logic [7:0]      emph_q,
  output logic [7:0]      thr_q,
  output logic [7:0]      mute_rate_q
);
  import lcc_pkg::*;

  // ------------------------------------------------------------------
  // storage; reserved bits are kept so reads return what was written
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      boost_q     <= LCC_RST_L1_BOOST;      // [R2]
      swing_q     <= LCC_RST_L1_SWING;      // [R4]
      emph_q      <= LCC_RST_L1_EMPH;       // [R6]
      thr_q       <= LCC_RST_L1_IDLE_THR;   // [R10]
      mute_rate_q <= LCC_RST_L2_MUTE_RATE;
    end else if (bus.wr_en) begin
      case (bus.addr)                       // [R19]
        LCC_OFS_L1_BOOST:     boost_q     <= bus.wdata;
        LCC_OFS_L1_SWING:     swing_q     <= bus.wdata;
        LCC_OFS_L1_EMPH:      emph_q      <= bus.wdata;
        LCC_OFS_L1_IDLE_THR:  thr_q       <= bus.wdata;
        LCC_OFS_L2_MUTE_RATE: mute_rate_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (bus.addr)                         // [R19]
      LCC_OFS_L1_BOOST:     bus.rdata = boost_q;
      LCC_OFS_L1_SWING:     bus.rdata = swing_q;
      LCC_OFS_L1_EMPH:      bus.rdata = emph_q;
      LCC_OFS_L1_IDLE_THR:  bus.rdata = thr_q;
      LCC_OFS_L2_MUTE_RATE: bus.rdata = mute_rate_q;
      default:              bus.rdata = LCC_UNMAPPED_READ;
    endcase
  end

  boost_write_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    (bus.wr_en && bus.addr == LCC_OFS_L1_BOOST) |=> boost_q == $past(bus.wdata))
    else $error("boost register write lost");
  emph_read_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    (bus.wr_en && bus.addr == LCC_OFS_L1_EMPH) |=> (bus.addr != LCC_OFS_L1_EMPH
    || bus.rdata == $past(bus.wdata)))
    else $error("emphasis register readback wrong");

endmodule : lcc_reg_bank

//--- lcc_ctrl_top.sv
// management bus slave and top level of the lane conditioning control bank
//
// Overview of operation
// R1: boost field six bits: enable bit, two-bit gain stage, three-bit level.
// R2: boost register resets to 0x20, boost path enabled.
// R3: strap-equivalent boost values 2A,30,32,39,35,37,3B,3D are recognised.
// R4: seven-bit swing codes 03,07,0F,1F,3F give 600 to 1400 mV.
// R5: emphasis bit 7 picks compatibility (0) or enhanced (1) profile.
// R6: emphasis bits 6:0 hold level; register resets to 0x03.
// R7: emphasis 0x01 is 0 dB, 0x88 is -6 dB, 0xA0 is -12 dB.
// R8: software must not write emphasis code 0xC0, it is reserved.
// R9: idle threshold bits 3:2 de-assert, bits 1:0 assert.
// R10: threshold codes 00..11 map 110/70 up to 190/150 mV, default 00.
// R11: with auto mute off, bit 4 decides lane-2 muting.
// R12: with auto mute on, lane-2 mutes from its own idle detection.
// R13: manual mute select 0 keeps output on, signal detection disabled.
// R14: manual mute select 1 forces lane-2 output into electrical idle.
// R15: with auto rate off, bit 0 sets lane-2 line rate.
// R16: with auto rate on, internal rate detection sets line rate.
// R17: rate select 0 means 2.5 Gbps, 1 means 5.0 Gbps.
// R18: software writes zeros to reserved bits; they have no function.
// R19: every lane register reads back the last value written.
`timescale 1ns/10ps
module lcc_ctrl_top (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       smb_scl_in,
  input  wire logic       smb_sda_in,
  output logic            smb_sda_out,
  output logic            smb_sda_oe_out,
  input  wire logic       lane2_idle_detect_in,
  input  wire logic       lane2_rate_detect_in,
  output logic            lane1_boost_enable_out,
  output logic [1:0]      lane1_gain_stage_pick_out,
  output logic [2:0]      lane1_boost_level_pick_out,
  output logic            lane1_boost_strap_equiv_out,
  output logic [6:0]      lane1_output_swing_level_out,
  output logic            lane1_emphasis_profile_out,
  output logic [6:0]      lane1_tx_emphasis_level_out,
  output logic            lane1_emphasis_reserved_out,
  output logic [1:0]      lane1_idle_deassert_thr_out,
  output logic [1:0]      lane1_idle_assert_thr_out,
  output logic            lane2_mute_out,
  output logic            lane2_signal_present_detect_en_out,
  output logic            lane2_rate_5g_out
);
  import lcc_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  lcc_bus_if  bus ();

  lcc_state_t state_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       wr_q;
  logic       rw_q;
  logic       mst_ack_q;
  logic       sda_oe_q;
  logic       sda_out_q;

  logic [7:0] boost_q;
  logic [7:0] swing_q;
  logic [7:0] emph_q;
  logic [7:0] thr_q;
  logic [7:0] mute_rate_q;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       byte_done;
  logic       rx_state;
  logic       cnt_clr;
  logic [LCC_NUM_STRAP-1:0] strap_hit;

  // ------------------------------------------------------------------
  // line events
  // ------------------------------------------------------------------
  // pins arrive synchronous to clk_in, so one stage of history suffices
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= smb_scl_in;
      sda_prev_q <= smb_sda_in;
    end
  end

  assign scl_rise  = smb_scl_in & ~scl_prev_q;
  assign scl_fall  = ~smb_scl_in & scl_prev_q;
  assign bus_start = smb_scl_in & scl_prev_q & sda_prev_q & ~smb_sda_in;
  assign bus_stop  = smb_scl_in & scl_prev_q & ~sda_prev_q & smb_sda_in;
  assign byte_done = (bit_cnt_q == LCC_BITS_PER_BYTE);
  assign rx_state  = (state_q == LCC_ADDR) || (state_q == LCC_REG) ||
                     (state_q == LCC_WDATA) || (state_q == LCC_RDATA);
  assign cnt_clr   = bus_start || (scl_fall && ((state_q == LCC_ADDR_ACK) ||
                     (state_q == LCC_REG_ACK) || (state_q == LCC_WDATA_ACK) ||
                     (state_q == LCC_RDATA_ACK)));

  // ------------------------------------------------------------------
  // bit counter and receive shifter
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (cnt_clr) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise && rx_state && !byte_done) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q   <= {shift_q[6:0], smb_sda_in};
    end
  end

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  // a start or stop is honoured in any state, so a host can always
  // recover a confused transfer without a reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q   <= LCC_IDLE;
      sda_oe_q  <= 1'b0;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      wr_q      <= 1'b0;
      rw_q      <= 1'b0;
      mst_ack_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (bus_start) begin
        state_q  <= LCC_ADDR;
        sda_oe_q <= 1'b0;
      end else if (bus_stop) begin
        state_q  <= LCC_IDLE;
        sda_oe_q <= 1'b0;
      end else if (scl_rise && state_q == LCC_RDATA_ACK) begin
        mst_ack_q <= ~smb_sda_in;
      end else if (scl_fall) begin
        case (state_q)
          LCC_ADDR: begin
            if (byte_done && shift_q[7:1] == LCC_SLAVE_ADDR) begin
              rw_q     <= shift_q[0];
              sda_oe_q <= 1'b1;
              state_q  <= LCC_ADDR_ACK;
            end else if (byte_done) begin
              state_q  <= LCC_IDLE;
            end
          end
          LCC_ADDR_ACK: begin
            if (rw_q) begin
              tx_q     <= bus.rdata;                   // [R19]
              sda_oe_q <= ~bus.rdata[7];
              state_q  <= LCC_RDATA;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= LCC_REG;
            end
          end
          LCC_REG: begin
            if (byte_done) begin
              ptr_q    <= shift_q;
              sda_oe_q <= 1'b1;
              state_q  <= LCC_REG_ACK;
            end
          end
          LCC_REG_ACK: begin
            sda_oe_q <= 1'b0;
            state_q  <= LCC_WDATA;
          end
          LCC_WDATA: begin
            if (byte_done) begin
              wr_q     <= 1'b1;                        // [R19]
              sda_oe_q <= 1'b1;
              state_q  <= LCC_WDATA_ACK;
            end
          end
          LCC_WDATA_ACK: begin
            sda_oe_q <= 1'b0;
            ptr_q    <= ptr_q + 8'h01;
            state_q  <= LCC_WDATA;
          end
          LCC_RDATA: begin
            if (byte_done) begin
              sda_oe_q <= 1'b0;
              ptr_q    <= ptr_q + 8'h01;
              state_q  <= LCC_RDATA_ACK;
            end else begin
              sda_oe_q <= ~tx_q[6];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
          LCC_RDATA_ACK: begin
            if (mst_ack_q) begin
              tx_q     <= bus.rdata;
              sda_oe_q <= ~bus.rdata[7];
              state_q  <= LCC_RDATA;
            end else begin
              state_q  <= LCC_IDLE;
            end
          end
          default: state_q <= LCC_IDLE;
        endcase
      end
    end
  end

  // open drain: the pad only ever pulls low
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  assign smb_sda_out    = sda_out_q;
  assign smb_sda_oe_out = sda_oe_q;
  assign bus.wr_en      = wr_q;
  assign bus.addr       = ptr_q;
  assign bus.wdata      = shift_q;

  // ------------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------------
  lcc_reg_bank u_bank (
    .clk_in               (clk_in),
    .reset_in             (reset_in),
    .bus                  (bus.bank),
    .boost_q              (boost_q),
    .swing_q              (swing_q),
    .emph_q               (emph_q),
    .thr_q                (thr_q),
    .mute_rate_q          (mute_rate_q)
  );

  // ------------------------------------------------------------------
  // lane-2 mute and rate selection
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lane2_mute_out                     <= 1'b0;
      lane2_signal_present_detect_en_out <= 1'b0;
    end else if (mute_rate_q[LCC_MUTE_AUTO_BIT]) begin
      lane2_mute_out                     <= lane2_idle_detect_in; // [R12]
      lane2_signal_present_detect_en_out <= 1'b1;
    end else begin
      lane2_mute_out                     <= mute_rate_q[LCC_MUTE_SEL_BIT]; // [R11] [R13] [R14]
      lane2_signal_present_detect_en_out <= 1'b0; // [R13]
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lane2_rate_5g_out <= LCC_RATE_2G5;
    end else if (mute_rate_q[LCC_RATE_AUTO_BIT]) begin
      lane2_rate_5g_out <= lane2_rate_detect_in;               // [R16]
    end else begin
      lane2_rate_5g_out <= mute_rate_q[LCC_RATE_SEL_BIT];      // [R15] [R17]
    end
  end

  // ------------------------------------------------------------------
  // status flags for the lane-1 settings
  // ------------------------------------------------------------------
  generate
    for (genvar i = 0; i < LCC_NUM_STRAP; i++) begin : g_strap
      assign strap_hit[i] = (boost_q[5:0] == LCC_BOOST_STRAP_VALS[i]);  // [R3]
    end
  endgenerate

  // the reserved emphasis code is flagged, not blocked: software owns it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      lane1_boost_strap_equiv_out <= 1'b0;
      lane1_emphasis_reserved_out <= 1'b0;
    end else begin
      lane1_boost_strap_equiv_out <= |strap_hit;                      // [R3]
      lane1_emphasis_reserved_out <= (emph_q == LCC_EMPH_RESERVED);   // [R8]
    end
  end

  // ------------------------------------------------------------------
  // lane-1 field outputs
  // ------------------------------------------------------------------
  // reserved bits are never routed to the lane, so they have no effect
  assign lane1_boost_enable_out       = boost_q[LCC_BOOST_EN_BIT];            // [R1] [R18]
  assign lane1_gain_stage_pick_out    =
    boost_q[LCC_BOOST_GAIN_MSB:LCC_BOOST_GAIN_LSB];                         // [R1]
  assign lane1_boost_level_pick_out   =
    boost_q[LCC_BOOST_LVL_MSB:LCC_BOOST_LVL_LSB];                           // [R1]
  assign lane1_output_swing_level_out = swing_q[LCC_SWING_MSB:0];             // [R4]
  assign lane1_emphasis_profile_out   = emph_q[LCC_EMPH_PROFILE_BIT];         // [R5] [R7]
  assign lane1_tx_emphasis_level_out  = emph_q[LCC_EMPH_LVL_MSB:0];           // [R6] [R7]
  assign lane1_idle_deassert_thr_out  =
    thr_q[LCC_THR_DEASSERT_MSB:LCC_THR_DEASSERT_LSB];                       // [R9] [R10]
  assign lane1_idle_assert_thr_out    =
    thr_q[LCC_THR_ASSERT_MSB:LCC_THR_ASSERT_LSB];                           // [R9] [R10]

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  addr_ack_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    (state_q == LCC_ADDR && scl_fall && byte_done && !bus_start && !bus_stop &&
     shift_q[7:1] == LCC_SLAVE_ADDR) |=> (smb_sda_oe_out && state_q == LCC_ADDR_ACK))
    else $error("own address not acknowledged");
  addr_miss_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    (state_q == LCC_ADDR && scl_fall && byte_done && !bus_start && !bus_stop &&
     shift_q[7:1] != LCC_SLAVE_ADDR) |=> (!smb_sda_oe_out && state_q == LCC_IDLE))
    else $error("foreign address acknowledged");
  write_pulse_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    $rose(wr_q) |=> (!wr_q && state_q == LCC_WDATA_ACK && smb_sda_oe_out))
    else $error("write strobe not single with ack");
  stop_release_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    bus_stop |=> (state_q == LCC_IDLE && !smb_sda_oe_out))
    else $error("stop did not release the line");
  bits_count_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    bit_cnt_q <= LCC_BITS_PER_BYTE)
    else $error("bit counter overran a byte");
  mute_auto_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R12]
    mute_rate_q[LCC_MUTE_AUTO_BIT] |=> lane2_mute_out == $past(lane2_idle_detect_in))
    else $error("auto mute does not follow idle detect");
  mute_forced_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    (!mute_rate_q[LCC_MUTE_AUTO_BIT] && mute_rate_q[LCC_MUTE_SEL_BIT]) |=> lane2_mute_out)
    else $error("manual mute select 1 did not mute");
  output_on_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R13]
    (!mute_rate_q[LCC_MUTE_AUTO_BIT] && !mute_rate_q[LCC_MUTE_SEL_BIT])
    |=> (!lane2_mute_out && !lane2_signal_present_detect_en_out))
    else $error("manual mute select 0 not on with detect off");
  rate_manual_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    !mute_rate_q[LCC_RATE_AUTO_BIT]
    |=> lane2_rate_5g_out == $past(mute_rate_q[LCC_RATE_SEL_BIT]))
    else $error("manual rate select not applied");
  rate_auto_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R16]
    mute_rate_q[LCC_RATE_AUTO_BIT] |=> lane2_rate_5g_out == $past(lane2_rate_detect_in))
    else $error("auto rate does not follow rate detect");

endmodule : lcc_ctrl_top

//--- lcc_host_model.sv
// management bus host model that drives the bank's serial pins
`timescale 1ns/10ps
module lcc_host_model (
  input  wire logic clk_in,
  input  wire logic sda_wire_in,
  output logic      scl_out,
  output logic      sda_out
);
  import lcc_pkg::*;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // each line state is held two clocks, above the slave's minimum phase length
  task automatic lv(input logic c, input logic d);
    @(negedge clk_in);
    scl_out = c;
    sda_out = d;
    @(negedge clk_in);
  endtask : lv
  task automatic bt(input logic b, output logic r);
    lv(1'b0, sda_out);
    lv(1'b0, b);
    lv(1'b1, b);
    r = sda_wire_in;
  endtask : bt
  // sending ff releases the line, so it also reads a byte and answers nack
  task automatic by(input logic [7:0] d, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(1'b1, a);
  endtask : by
  task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic rd,
                        input logic [7:0] wd, output logic [7:0] rdv, output logic nak);
    logic [7:0] r;
    logic       a0, a1, a2, an;
    lv(1'b0, sda_out);
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    by({dev, 1'b0}, r, a0);
    by(ofs, r, a1);
    if (rd) begin
      lv(1'b0, sda_out);
      lv(1'b0, 1'b1);
      lv(1'b1, 1'b1);
      lv(1'b1, 1'b0);
      by({dev, 1'b1}, r, a2);
      // the closing nack is the host's own, so it is not counted
      by(8'hff, rdv, an);
    end else by(wd, rdv, a2);
    lv(1'b0, sda_out);
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
    nak = a0 | a1 | a2;
  endtask : access
endmodule : lcc_host_model

//--- testbench.sv
// self-checking testbench for the lane conditioning control bank
`timescale 1ns/10ps
module testbench;
  import lcc_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, idle_det = 1'b0, rate_det = 1'b0;
  logic scl, hsda, oe, sdo, ben, strap, prof, resv, mute, sdet, r5g, nak;
  logic [1:0] gain_stage_pick, dthr, athr;
  logic [2:0] blvl;
  logic [6:0] swing, elvl;
  logic [7:0] rd;
  logic [7:0] rst_t [5] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00};
  logic [7:0] ofs_t [5] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1c};
  logic [6:0] sw_t [5] = '{7'h03, 7'h07, 7'h0f, 7'h1f, 7'h3f};
  logic [7:0] em_t [4] = '{8'h01, 8'h88, 8'ha0, 8'hc0};
  // row: register value, idle detect, rate detect, expected {sig detect, mute, 5g}
  logic [12:0] mr_t [4] = '{13'h020a, 13'h0031, 13'h0456, 13'h064d};
  int num_errors = 0;
  int n_checks = 0;
  // open-drain wire with pull-up: the pad value counts only while enabled
  wire sda_w = hsda & (oe ? sdo : 1'b1);
  always #20 clk_in = ~clk_in;
  lcc_ctrl_top lcc_ctrl_top_inst (.clk_in(clk_in), .reset_in(reset_in), .smb_scl_in(scl),
    .smb_sda_in(sda_w), .smb_sda_out(sdo), .smb_sda_oe_out(oe), .lane2_idle_detect_in(idle_det),
    .lane2_rate_detect_in(rate_det), .lane1_boost_enable_out(ben),
    .lane1_gain_stage_pick_out(gain_stage_pick), .lane1_boost_level_pick_out(blvl),
    .lane1_boost_strap_equiv_out(strap), .lane1_output_swing_level_out(swing),
    .lane1_emphasis_profile_out(prof), .lane1_tx_emphasis_level_out(elvl),
    .lane1_emphasis_reserved_out(resv), .lane1_idle_deassert_thr_out(dthr),
    .lane1_idle_assert_thr_out(athr), .lane2_mute_out(mute),
    .lane2_signal_present_detect_en_out(sdet), .lane2_rate_5g_out(r5g));
  lcc_host_model lcc_host_model_inst (.clk_in(clk_in), .sda_wire_in(sda_w), .scl_out(scl),
    .sda_out(hsda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    lcc_host_model_inst.access(LCC_SLAVE_ADDR, ofs, 1'b0, d, rd, nak);
    chk({7'h0, nak}, 8'h00);
  endtask : wr
  task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
    lcc_host_model_inst.access(LCC_SLAVE_ADDR, ofs, 1'b1, 8'h00, rd, nak);
    chk({7'h0, nak}, 8'h00);
    chk(rd, exp);
  endtask : rdc
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    chk({2'b0, ben, gain_stage_pick, blvl}, 8'h20);
    chk({1'b0, swing}, 8'h03);
    chk({prof, elvl}, 8'h03);
    foreach (ofs_t[i]) rdc(ofs_t[i], rst_t[i]);
    for (int i = 0; i < LCC_NUM_STRAP; i++) begin
      wr(8'h16, {2'b00, LCC_BOOST_STRAP_VALS[i]});
      chk({7'h0, strap}, 8'h01);
      chk({2'b0, ben, gain_stage_pick, blvl}, {2'b0, LCC_BOOST_STRAP_VALS[i]});
    end
    wr(8'h16, 8'h3c);
    chk({7'h0, strap}, 8'h00);
    rdc(8'h16, 8'h3c);
    foreach (sw_t[i]) begin
      wr(8'h17, {1'b0, sw_t[i]});
      chk({1'b0, swing}, {1'b0, sw_t[i]});
    end
    rdc(8'h17, 8'h3f);
    foreach (em_t[i]) begin
      wr(8'h18, em_t[i]);
      chk({prof, elvl}, em_t[i]);
      chk({7'h0, resv}, {7'h0, em_t[i] == 8'hc0});
    end
    rdc(8'h18, 8'hc0);
    wr(8'h19, 8'h0b);
    chk({4'h0, dthr, athr}, 8'h0b);
    rdc(8'h19, 8'h0b);
    foreach (mr_t[i]) begin
      @(negedge clk_in);
      idle_det = mr_t[i][4];
      rate_det = mr_t[i][3];
      wr(8'h1c, mr_t[i][12:5]);
      chk({5'h0, sdet, mute, r5g}, {5'h0, mr_t[i][2:0]});
    end
    idle_det = 1'b1;
    repeat (3) @(negedge clk_in);
    chk({7'h0, mute}, 8'h01);
    rdc(8'h1a, 8'h00);
    lcc_host_model_inst.access(LCC_SLAVE_ADDR ^ 7'h01, 8'h16, 1'b0, 8'h00, rd, nak);
    chk({7'h0, nak}, 8'h01);
    rdc(8'h16, 8'h3c);
    @(negedge clk_in);
    reset_in = 1'b1;
    @(negedge clk_in);
    reset_in = 1'b0;
    rdc(8'h16, 8'h20);
    rdc(8'h1c, 8'h00);
    chk({5'h0, sdet, mute, r5g}, 8'h00);
    wrap_up();
  end
endmodule : testbench
